// File: core/dbt_pkg.sv
/*
 * dbt_pkg: constants and carrier types for the debug break / event / trace
 * unit. Assumes 32-bit CPU addresses and data, one CPU clock domain.
 */
package dbt_pkg;
	// ==========================================================
	// register map (byte offsets, one word apart, on the plain register port)
	localparam logic [7:0] DBT_CTRL_OFF   = 8'h00;
	localparam logic [7:0] DBT_EVADDR_OFF = 8'h04;
	localparam logic [7:0] DBT_EVCFG_OFF  = 8'h08;
	localparam logic [7:0] DBT_DELAY_OFF  = 8'h0c;
	localparam logic [7:0] DBT_PC_OFF     = 8'h10;
	localparam logic [7:0] DBT_STAT_OFF   = 8'h14;
	localparam logic [7:0] DBT_CAUSE_OFF  = 8'h18;
	localparam logic [7:0] DBT_FILL_OFF   = 8'h1c;
	localparam logic [7:0] DBT_EVCNT_OFF  = 8'h20;
	// ==========================================================
	// control register fields
	localparam int DBT_C_RUN    = 0;  // write 1: run pulse
	localparam int DBT_C_STEP   = 1;  // write 1: single step pulse
	localparam int DBT_C_FBRK   = 2;  // write 1: forced break pulse
	localparam int DBT_C_FRST   = 3;  // write 1: forced reset pulse
	localparam int DBT_C_SETPC  = 4;  // write 1: load pc before run
	localparam int DBT_C_HWBEN  = 5;
	localparam int DBT_C_NRT    = 6;  // non-real-time priority
	localparam int DBT_C_MODE   = 8;  // 3-bit recording mode
	localparam int DBT_C_TSEN   = 11;
	localparam int DBT_C_TRBR   = 12; // trace branch
	localparam int DBT_C_TRCPU  = 13; // trace cpu access
	localparam int DBT_C_TRDMA  = 14; // trace dma access
	// event config fields
	localparam int DBT_E_FETCH  = 0;
	localparam int DBT_E_READ   = 1;
	localparam int DBT_E_WRITE  = 2;
	localparam int DBT_E_DMA    = 3;
	// ==========================================================
	localparam logic [31:0] DBT_CTRL_RST  = 32'h0000_0000;
	localparam logic [31:0] DBT_DELAY_RST = 32'h0000_0010;
	localparam int          DBT_DEPTH     = 16;
	localparam int          DBT_AW        = 4;
	localparam int          DBT_FORST_CYC = 4; // forced reset width
	// ==========================================================
	typedef enum logic [2:0] {
		DBT_M_RING, DBT_M_FSTOP, DBT_M_FBREAK, DBT_M_DSTOP, DBT_M_DBREAK
	} dbt_mode_t;
	typedef enum logic [1:0] {
		DBT_T_BRANCH, DBT_T_CPU, DBT_T_DMA, DBT_T_TSTAMP
	} dbt_tag_t;
	// cause bit positions
	localparam int DBT_K_HW = 0;
	localparam int DBT_K_SW = 1;
	localparam int DBT_K_FORCE = 2;
	localparam int DBT_K_FULL = 3;
	localparam int DBT_K_DELAY = 4;
	localparam int DBT_K_STEP = 5;
	// one cpu bus or branch observation
	typedef struct packed {
		logic        valid;
		logic        fetch;  // instruction fetch
		logic        write;
		logic        sysreg; // gpr or system register access
		logic [31:0] pc;
		logic [31:0] addr;
		logic [31:0] data;
	} dbt_cpu_t;
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
		logic [31:0] data;
	} dbt_dma_t;
	// one trace record: tag, direction, three words, time stamp
	typedef struct packed {
		dbt_tag_t    tag;
		logic        write;
		logic [31:0] w0;
		logic [31:0] w1;
		logic [31:0] w2;
		logic [31:0] tstamp;
	} dbt_rec_t;
endpackage : dbt_pkg

// File: core/dbt_unit.sv
/*
 * dbt_unit: debug break, event and trace unit. Holds event match, break
 * logic, run control and a flip-flop trace store drained by the emulator.
 * Assumes cpu bus observations arrive on clock_i; pins from the emulator
 * are asynchronous and are synchronised here.
 */
// Implementation choices: the plain strobed port and the register addresses.
// What this block does
// R1 - events from cpu and dma bus cycles
// R2 - event feeds break, trace and count
// R3 - armed hardware break halts on match
// R4 - host patches break opcode, restores later
// R5 - forced break request halts unconditionally
// R6 - forced reset request resets the cpu
// R7 - trace-full break halts when memory full
// R8 - delay trigger: record more, then halt
// R9 - real-time: drop trace, never stall cpu
// R10 - non-real-time: stall cpu when trace busy
// R11 - branch record holds source and destination
// R12 - cpu access: pc, address, data, direction
// R13 - register accesses make no access record
// R14 - dma record: address, data, direction
// R15 - time stamp counts cycles since last
// R16 - single step runs one instruction
// R17 - host loads any pc before run
// R18 - ring mode overwrites oldest records
// R19 - full stop mode stops recording only
// R20 - each record carries type tag
// R21 - simultaneous causes: one halt, all flagged
`timescale 1ns/10ps
module dbt_unit
	import dbt_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        reset_n_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	input  wire dbt_cpu_t    cpu_i,
	input  wire logic        cpu_branch_i,
	input  wire logic [31:0] branch_dst_i,
	input  wire logic        sw_break_i,
	input  wire logic        retire_i,
	input  wire dbt_dma_t    dma_i,
	input  wire logic        force_break_pin_i,
	input  wire logic        force_reset_pin_i,
	output logic             cpu_halt_o,
	output logic             cpu_stall_o,
	output logic             cpu_reset_o,
	output logic             pc_load_o,
	output logic      [31:0] pc_value_o,
	output logic             trace_valid_o,
	input  wire logic        trace_ready_i,
	output dbt_rec_t         trace_rec_o
);
	// ==========================================================
	// reset release and pin synchronisers
	logic [1:0] rst_sync_r;
	logic       rst_n;
	logic [1:0] fb_sync_r, fr_sync_r;
	logic       fb_prev_r, fr_prev_r;
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) rst_sync_r <= 2'b00;
		else rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			fb_sync_r <= 2'b00;
			fr_sync_r <= 2'b00;
			fb_prev_r <= 1'b0;
			fr_prev_r <= 1'b0;
		end else begin
			fb_sync_r <= {fb_sync_r[0], force_break_pin_i};
			fr_sync_r <= {fr_sync_r[0], force_reset_pin_i};
			fb_prev_r <= fb_sync_r[1];
			fr_prev_r <= fr_sync_r[1];
		end
	end
	// ==========================================================
	// registers
	logic [31:0] ctrl_r, evaddr_r, evcfg_r, delay_r, pc_r, evcnt_r;
	logic [5:0]  cause_r;
	logic        halted_r, step_r, stopped_r, trig_r;
	logic [31:0] dcount_r;
	logic        ctrl_wr, run_req, step_req, fbrk_req, frst_req;
	dbt_mode_t   mode;
	assign ctrl_wr  = reg_wr_i && (reg_addr_i == DBT_CTRL_OFF);
	assign run_req  = ctrl_wr && reg_wdata_i[DBT_C_RUN];
	assign step_req = ctrl_wr && reg_wdata_i[DBT_C_STEP];
	assign fbrk_req = (ctrl_wr && reg_wdata_i[DBT_C_FBRK]) ||
		(fb_sync_r[1] && !fb_prev_r);
	assign frst_req = (ctrl_wr && reg_wdata_i[DBT_C_FRST]) ||
		(fr_sync_r[1] && !fr_prev_r);
	assign mode = dbt_mode_t'(ctrl_r[DBT_C_MODE +: 3]);
	// ==========================================================
	// event match on cpu and dma cycles
	logic ev_cpu, ev_dma, ev_hit;
	function automatic logic dir_ok(input logic wr, input logic [31:0] c);
		dir_ok = wr ? c[DBT_E_WRITE] : c[DBT_E_READ];
	endfunction : dir_ok
	assign ev_cpu = cpu_i.valid && !cpu_i.sysreg &&
		(cpu_i.addr == evaddr_r) &&
		(cpu_i.fetch ? evcfg_r[DBT_E_FETCH] : dir_ok(cpu_i.write, evcfg_r)); // R1
	assign ev_dma = dma_i.valid && evcfg_r[DBT_E_DMA] &&
		(dma_i.addr == evaddr_r) && dir_ok(dma_i.write, evcfg_r); // R1
	assign ev_hit = (ev_cpu || ev_dma) && !halted_r; // R2
	// ==========================================================
	// trace store: flip-flop ring, index addressed
	dbt_rec_t          mem_r [DBT_DEPTH];
	logic [DBT_AW-1:0] wp_r, rp_r;
	logic [DBT_AW:0]   fill_r;
	logic [31:0]       ts_r;
	logic              full, rec_en, push, pop, can_push, dly_done;
	dbt_rec_t          rec;
	assign full   = (fill_r == (DBT_AW+1)'(DBT_DEPTH));
	assign rec_en = !stopped_r && !halted_r && !dly_done; // R8
	// build a record; only one source per cycle, branch first
	always_comb begin
		rec        = '0;
		rec.tstamp = ctrl_r[DBT_C_TSEN] ? ts_r : 32'h0000_0000; // R15
		push       = 1'b0;
		if (cpu_branch_i && ctrl_r[DBT_C_TRBR]) begin
			rec.tag = DBT_T_BRANCH; // R20
			rec.w0  = cpu_i.pc; // R11
			rec.w1  = branch_dst_i; // R11
			push    = 1'b1;
		end else if (cpu_i.valid && !cpu_i.fetch && !cpu_i.sysreg &&
			ctrl_r[DBT_C_TRCPU]) begin // R13
			rec.tag   = DBT_T_CPU; // R20
			rec.write = cpu_i.write; // R12
			rec.w0    = cpu_i.pc;
			rec.w1    = cpu_i.addr;
			rec.w2    = cpu_i.data;
			push      = 1'b1;
		end else if (dma_i.valid && ctrl_r[DBT_C_TRDMA]) begin
			rec.tag   = DBT_T_DMA; // R20
			rec.write = dma_i.write; // R14
			rec.w1    = dma_i.addr;
			rec.w2    = dma_i.data;
			push      = 1'b1;
		end
		push = push && rec_en;
	end
	// ring and delay modes always write: oldest record is pushed out when
	// full, so a trigger on a full store still collects its count
	assign can_push = push && (!full || mode == DBT_M_RING ||
		mode inside {DBT_M_DSTOP, DBT_M_DBREAK}); // R18 R19
	assign pop = trace_valid_o && trace_ready_i;
	assign trace_valid_o = (fill_r != '0);
	assign trace_rec_o   = mem_r[rp_r];
	always_ff @(posedge clock_i) begin
		if (can_push) mem_r[wp_r] <= rec;
	end
	// pointers; a push on full in overwrite drops the oldest
	logic drop_old;
	assign drop_old = can_push && full && !pop; // R18
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
			fill_r <= '0;
			ts_r <= 32'h0000_0000;
		end else begin
			if (can_push) wp_r <= wp_r + 1'b1;
			if (pop || drop_old) rp_r <= rp_r + 1'b1;
			if (can_push && !pop && !full) fill_r <= fill_r + 1'b1;
			else if (pop && !can_push) fill_r <= fill_r - 1'b1;
			ts_r <= can_push ? 32'h0000_0001 : ts_r + 1'b1; // R15
		end
	end
	// ==========================================================
	// delay trigger and stop of recording
	logic full_brk;
	assign dly_done = trig_r && (dcount_r == 32'h0000_0000);
	assign full_brk = (mode == DBT_M_FBREAK) && full && push; // R7
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			trig_r <= 1'b0;
			dcount_r <= 32'h0000_0000;
			stopped_r <= 1'b0;
		end else if (run_req) begin
			trig_r <= 1'b0;
			stopped_r <= 1'b0;
		end else begin
			if (!trig_r && ev_hit && mode inside {DBT_M_DSTOP, DBT_M_DBREAK}) begin
				trig_r <= 1'b1; // R8
				dcount_r <= delay_r;
			end else if (trig_r && can_push && dcount_r != '0)
				dcount_r <= dcount_r - 1'b1; // R8
			if (dly_done || (mode == DBT_M_FSTOP && full) || full_brk)
				stopped_r <= 1'b1; // R19
		end
	end
	// ==========================================================
	// halt causes: all flagged in one cycle, halt taken once
	logic [5:0] causes;
	assign causes[DBT_K_HW]    = ctrl_r[DBT_C_HWBEN] && ev_hit; // R3
	assign causes[DBT_K_SW]    = sw_break_i && !halted_r; // R4
	assign causes[DBT_K_FORCE] = fbrk_req && !halted_r; // R5
	assign causes[DBT_K_FULL]  = full_brk && !halted_r; // R7
	assign causes[DBT_K_DELAY] = dly_done && !stopped_r && !halted_r &&
		(mode == DBT_M_DBREAK); // R8
	assign causes[DBT_K_STEP]  = step_r && retire_i; // R16
	logic [2:0] rstcnt_r;
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			halted_r <= 1'b1;
			step_r <= 1'b0;
			cause_r <= '0;
			rstcnt_r <= '0;
		end else begin
			if (|causes) begin
				halted_r <= 1'b1; // R21
				step_r <= 1'b0;
				cause_r <= causes; // R21
			end else if ((run_req || step_req) && halted_r) begin
				halted_r <= 1'b0;
				step_r <= step_req; // R16
				cause_r <= '0;
			end
			if (frst_req) rstcnt_r <= 3'(DBT_FORST_CYC); // R6
			else if (rstcnt_r != '0) rstcnt_r <= rstcnt_r - 1'b1;
		end
	end
	assign cpu_halt_o  = halted_r;
	assign cpu_reset_o = (rstcnt_r != '0); // R6
	// non-real-time stalls while a push meets a full store in any mode but ring
	assign cpu_stall_o = ctrl_r[DBT_C_NRT] && full && push &&
		!pop && (mode != DBT_M_RING); // R10
	// real-time: no stall term; past full, records are dropped in full-stop and full-break modes R9
	// ==========================================================
	// pc load before run
	assign pc_load_o  = run_req && reg_wdata_i[DBT_C_SETPC] && halted_r; // R17
	assign pc_value_o = pc_r;
	// ==========================================================
	// register writes and event counter
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= DBT_CTRL_RST;
			evaddr_r <= 32'h0000_0000;
			evcfg_r <= 32'h0000_0000;
			delay_r <= DBT_DELAY_RST;
			pc_r <= 32'h0000_0000;
			evcnt_r <= 32'h0000_0000;
		end else begin
			if (ctrl_wr) ctrl_r <= reg_wdata_i & 32'h0000_7fe0;
			if (reg_wr_i && reg_addr_i == DBT_EVADDR_OFF) evaddr_r <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == DBT_EVCFG_OFF) evcfg_r <= reg_wdata_i & 32'h0000_000f;
			if (reg_wr_i && reg_addr_i == DBT_DELAY_OFF) delay_r <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == DBT_PC_OFF) pc_r <= reg_wdata_i; // R17
			if (reg_wr_i && reg_addr_i == DBT_EVCNT_OFF) evcnt_r <= '0;
			else if (ev_hit) evcnt_r <= evcnt_r + 1'b1; // R2
		end
	end
	// read mux, data one cycle after the strobe
	logic [31:0] rd_mux;
	always_comb begin
		case (reg_addr_i)
			DBT_CTRL_OFF:   rd_mux = ctrl_r;
			DBT_EVADDR_OFF: rd_mux = evaddr_r;
			DBT_EVCFG_OFF:  rd_mux = evcfg_r;
			DBT_DELAY_OFF:  rd_mux = delay_r;
			DBT_PC_OFF:     rd_mux = pc_r;
			DBT_STAT_OFF:   rd_mux = {26'h0, cpu_reset_o, cpu_stall_o,
				full, trig_r, stopped_r, halted_r};
			DBT_CAUSE_OFF:  rd_mux = {26'h0, cause_r}; // R21
			DBT_FILL_OFF:   rd_mux = {27'h0, fill_r};
			DBT_EVCNT_OFF:  rd_mux = evcnt_r;
			default:        rd_mux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) reg_rdata_o <= 32'h0000_0000;
		else reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
	end
endmodule : dbt_unit

// File: testbench/dbt_host.sv
/* dbt_host: emulator-side model that drains trace and pulses pins.
   Assumes it shares clock_i with dbt_unit. */
`timescale 1ns/10ps
module dbt_host
	import dbt_pkg::*;
(
	input  wire logic     clock_i,
	input  wire logic     trace_valid_i,
	input  wire dbt_rec_t trace_rec_i,
	output logic          trace_ready_o,
	output logic          brk_pin_o,
	output logic          rst_pin_o
);
	// ==========================================
	// drain side; hold_r models a slow host link
	logic     hold_r;
	dbt_rec_t got[$];
	initial begin
		hold_r    = 1'b0;
		brk_pin_o = 1'b0;
		rst_pin_o = 1'b0;
	end
	assign trace_ready_o = !hold_r;
	always @(posedge clock_i) begin
		if (trace_valid_i && trace_ready_o) begin
			got.push_back(trace_rec_i);
		end
	end
	// pin held 6 cycles so the 2-ff sync sees it
	task automatic pulse(input logic sel);
		brk_pin_o <= !sel;
		rst_pin_o <= sel;
		repeat (6) @(posedge clock_i);
		brk_pin_o <= 1'b0;
		rst_pin_o <= 1'b0;
		@(posedge clock_i);
	endtask : pulse
endmodule : dbt_host

// File: testbench/dbt_unit_checker.sv
/* dbt_unit_checker: port assertions for dbt_unit, bound at the foot.
   Assumes one clock domain and the async active-low reset. */
`timescale 1ns/10ps
module dbt_unit_checker
	import dbt_pkg::*;
(
	input wire logic     clock_i,
	input wire logic     reset_n_i,
	input wire logic     reg_wr_i,
	input wire logic     force_break_pin_i,
	input wire logic     force_reset_pin_i,
	input wire logic     trace_ready_i,
	input wire logic     cpu_halt_o,
	input wire logic     cpu_stall_o,
	input wire logic     cpu_reset_o,
	input wire logic     pc_load_o,
	input wire logic     trace_valid_o,
	input wire dbt_rec_t trace_rec_o
);
	// ==========================================
	// run control and trace store relations
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	chk_force_brk: assert property (
		$rose(force_break_pin_i) |-> ##[1:5] cpu_halt_o)
		else $error("forced break did not halt");
	chk_rst_delay: assert property (
		$rose(force_reset_pin_i) |-> ##[1:6] cpu_reset_o)
		else $error("forced reset not issued");
	chk_rst_width: assert property (
		$rose(cpu_reset_o) |-> cpu_reset_o[*4] ##1 !cpu_reset_o)
		else $error("cpu reset width wrong");
	chk_stall_data: assert property (
		cpu_stall_o |-> trace_valid_o && !trace_ready_i && !cpu_halt_o)
		else $error("stall with empty trace store");
	chk_head_hold: assert property (
		cpu_halt_o && trace_valid_o && !trace_ready_i
		|=> $stable(trace_rec_o))
		else $error("head record changed while frozen");
	chk_pc_load: assert property (
		pc_load_o |-> reg_wr_i)
		else $error("pc load without register write");
	// a forced reset may restart the cpu, so it is excluded
	chk_halt_hold: assert property (
		cpu_halt_o && !reg_wr_i && !$past(reg_wr_i) && !cpu_reset_o
		&& !$past(cpu_reset_o) && !force_reset_pin_i |=> cpu_halt_o)
		else $error("halt released without request");
	chk_drain_only: assert property (
		$fell(trace_valid_o) |-> $past(trace_ready_i))
		else $error("trace store emptied without drain");
endmodule : dbt_unit_checker
bind dbt_unit dbt_unit_checker dbt_unit_checker_inst (.clock_i, .reset_n_i,
	.reg_wr_i, .force_break_pin_i, .force_reset_pin_i, .trace_ready_i,
	.cpu_halt_o, .cpu_stall_o, .cpu_reset_o, .pc_load_o, .trace_valid_o,
	.trace_rec_o);

// File: testbench/dbt_unit_test.sv
/* dbt_unit_test: register-driven tests of dbt_unit with a host model.
   Assumes dbt_pkg, dbt_host and the bound checker are compiled first. */
`timescale 1ns/10ps
module dbt_unit_test
	import dbt_pkg::*;
;
	// ==========================================
	// stimulus and observed signals
	logic        clock_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = '0;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic        cpu_branch_i = 1'b0;
	logic [31:0] branch_dst_i = '0;
	logic        sw_break_i = 1'b0;
	logic        retire_i = 1'b0;
	dbt_cpu_t    cpu_i = '0;
	dbt_dma_t    dma_i = '0;
	logic        force_break_pin_i, force_reset_pin_i, trace_ready_i;
	logic        cpu_halt_o, cpu_stall_o, cpu_reset_o, pc_load_o, ld;
	logic        trace_valid_o;
	logic [31:0] reg_rdata_o, pc_value_o;
	dbt_rec_t    trace_rec_o;
	int          err_total = 0;
	int          checks = 0;
	always #25 clock_i = ~clock_i;
	dbt_unit dbt_unit_inst (.clock_i, .reset_n_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .cpu_i, .cpu_branch_i,
		.branch_dst_i, .sw_break_i, .retire_i, .dma_i, .force_break_pin_i,
		.force_reset_pin_i, .cpu_halt_o, .cpu_stall_o, .cpu_reset_o,
		.pc_load_o, .pc_value_o, .trace_valid_o, .trace_ready_i,
		.trace_rec_o);
	dbt_host dbt_host_inst (.clock_i, .trace_valid_i(trace_valid_o),
		.trace_rec_i(trace_rec_o), .trace_ready_o(trace_ready_i),
		.brk_pin_o(force_break_pin_i), .rst_pin_o(force_reset_pin_i));
	// ==========================================
	// compare and bus tasks; wr, rd and wait_halt end just after a rising edge
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic cmp_rec(input int i, input dbt_tag_t t, input logic w,
		input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
		dbt_rec_t r;
		r = dbt_host_inst.got[i];
		cmp({30'h0, r.tag}, {30'h0, t});
		if (t != DBT_T_DMA) cmp(r.w0, a);
		cmp(r.w1, b);
		if (t != DBT_T_BRANCH) cmp(r.w2, c);
		if (t != DBT_T_BRANCH) cmp({31'h0, r.write}, {31'h0, w});
	endtask : cmp_rec
	// gap cycle after each strobe keeps one assignment per step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(negedge clock_i) ld = pc_load_o;
		@(posedge clock_i) reg_wr_i <= 1'b0;
		@(posedge clock_i);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clock_i) reg_rd_i <= 1'b0;
		@(negedge clock_i) cmp(reg_rdata_o, exp);
		@(posedge clock_i);
	endtask : rd
	task automatic wait_halt(input logic exp);
		int n;
		n = 0;
		while (cpu_halt_o !== exp && n < 12) begin
			@(negedge clock_i);
			n++;
		end
		cmp({31'h0, cpu_halt_o}, {31'h0, exp});
		@(posedge clock_i);
	endtask : wait_halt
	task automatic results();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results
	// ==========================================
	// watchdog, generous against the few hundred cycles needed
	initial begin
		repeat (5000) @(posedge clock_i);
		err_total++;
		results();
	end
	// ==========================================
	// main sequence
	initial begin
		logic [31:0] ctl[2] = '{32'h0000_2141, 32'h0000_2201};
		int          n;
		repeat (10) @(posedge clock_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		rd(DBT_CTRL_OFF, DBT_CTRL_RST);
		rd(DBT_DELAY_OFF, DBT_DELAY_RST);
		rd(8'h3c, 32'h0000_0000);
		rd(DBT_STAT_OFF, 32'h0000_0001);
		$display("test reset done");
		// run from a loaded pc, ring mode, all trace kinds with stamps
		wr(DBT_PC_OFF, 32'h0000_0100);
		wr(DBT_CTRL_OFF, 32'h0000_7811);
		cmp({31'h0, ld}, 32'h0000_0001);
		cmp(pc_value_o, 32'h0000_0100);
		wait_halt(1'b0);
		dbt_host_inst.hold_r <= 1'b1;
		cpu_i.pc     <= 32'h0000_0200;
		cpu_branch_i <= 1'b1;
		branch_dst_i <= 32'h0000_0300;
		@(posedge clock_i) cpu_branch_i <= 1'b0;
		cpu_i <= '{1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_0304, 32'h0000_4000,
			32'h1234_5678};
		@(posedge clock_i) cpu_i.sysreg <= 1'b1;
		@(posedge clock_i) cpu_i <= '0;
		dma_i <= '{1'b1, 1'b1, 32'h0000_5000, 32'h0000_abcd};
		@(posedge clock_i) dma_i <= '0;
		rd(DBT_FILL_OFF, 32'h0000_0003);
		dbt_host_inst.hold_r <= 1'b0;
		repeat (6) @(posedge clock_i);
		cmp(dbt_host_inst.got.size(), 32'h0000_0003);
		cmp_rec(0, DBT_T_BRANCH, 1'b0, 32'h0000_0200, 32'h0000_0300, '0);
		cmp_rec(1, DBT_T_CPU, 1'b0, 32'h0000_0304, 32'h0000_4000,
			32'h1234_5678);
		cmp_rec(2, DBT_T_DMA, 1'b1, '0, 32'h0000_5000, 32'h0000_abcd);
		cmp(dbt_host_inst.got[1].tstamp, 32'h0000_0001);
		cmp(dbt_host_inst.got[2].tstamp, 32'h0000_0002);
		dbt_host_inst.got.delete();
		$display("test trace done");
		// hardware event and break opcode in one cycle
		wr(DBT_EVADDR_OFF, 32'h0000_2000);
		wr(DBT_EVCFG_OFF, 32'h0000_0002);
		wr(DBT_CTRL_OFF, 32'h0000_0021);
		cpu_i <= '{1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_2010, 32'h0000_2000, '0};
		sw_break_i <= 1'b1;
		@(posedge clock_i) cpu_i <= '0;
		sw_break_i <= 1'b0;
		wait_halt(1'b1);
		rd(DBT_CAUSE_OFF, 32'h0000_0003);
		rd(DBT_EVCNT_OFF, 32'h0000_0001);
		$display("test break done");
		// forced reset then forced break, then one step
		wr(DBT_CTRL_OFF, 32'h0000_0001);
		n = 0;
		fork
			dbt_host_inst.pulse(1'b1);
			repeat (14) @(negedge clock_i) n += int'(cpu_reset_o);
		join
		@(posedge clock_i);
		cmp(n, 32'h0000_0004);
		dbt_host_inst.pulse(1'b0);
		wait_halt(1'b1);
		rd(DBT_CAUSE_OFF, 32'h0000_0004);
		wr(DBT_CTRL_OFF, 32'h0000_0002);
		wait_halt(1'b0);
		retire_i <= 1'b1;
		@(posedge clock_i) retire_i <= 1'b0;
		wait_halt(1'b1);
		rd(DBT_CAUSE_OFF, 32'h0000_0020);
		$display("test control done");
		// fill with host stalled: full-stop stalls, full-break halts
		for (int k = 0; k < 2; k++) begin
			dbt_host_inst.hold_r <= 1'b1;
			wr(DBT_CTRL_OFF, ctl[k]);
			wait_halt(1'b0);
			for (int i = 0; i < 17; i++) begin
				cpu_i <= '{1'b1, 1'b0, 1'b1, 1'b0, 32'h0000_0400,
					32'h0000_6000 + i, 32'h0000_0100 + i};
				// stall stands only while the refused push is pending
				if (i == 16) @(negedge clock_i)
					cmp({31'h0, cpu_stall_o}, 32'(k == 0));
				@(posedge clock_i);
			end
			@(negedge clock_i) cmp({31'h0, cpu_stall_o}, 32'h0000_0000);
			@(posedge clock_i) cpu_i <= '0;
			wait_halt(k == 1);
			rd(DBT_FILL_OFF, 32'h0000_0010);
			dbt_host_inst.hold_r <= 1'b0;
			repeat (20) @(posedge clock_i);
			cmp(dbt_host_inst.got.size(), 32'h0000_0010);
			dbt_host_inst.got.delete();
		end
		rd(DBT_CAUSE_OFF, 32'h0000_0008);
		$display("test fill done");
		// delay break on a full ring: dma write event, three records more
		wr(DBT_DELAY_OFF, 32'h0000_0003);
		wr(DBT_EVADDR_OFF, 32'h0000_7000);
		wr(DBT_EVCFG_OFF, 32'h0000_000c);
		dbt_host_inst.hold_r <= 1'b1;
		wr(DBT_CTRL_OFF, 32'h0000_6401);
		wait_halt(1'b0);
		for (int i = 0; i < 25; i++) begin
			cpu_i <= '{i != 20, 1'b0, 1'b1, 1'b0, 32'h0000_0400,
				32'h0000_6000 + i, 32'h0000_0100 + i};
			dma_i <= '{i == 20, 1'b1, 32'h0000_7000, 32'h0000_0055};
			@(posedge clock_i);
		end
		cpu_i <= '0;
		dma_i <= '0;
		wait_halt(1'b1);
		rd(DBT_CAUSE_OFF, 32'h0000_0010);
		rd(DBT_STAT_OFF, 32'h0000_000f);
		dbt_host_inst.hold_r <= 1'b0;
		repeat (20) @(posedge clock_i);
		cmp(dbt_host_inst.got.size(), 32'h0000_0010);
		cmp_rec(0, DBT_T_CPU, 1'b1, 32'h0000_0400, 32'h0000_6008,
			32'h0000_0108);
		cmp_rec(12, DBT_T_DMA, 1'b1, '0, 32'h0000_7000,
			32'h0000_0055);
		cmp_rec(15, DBT_T_CPU, 1'b1, 32'h0000_0400, 32'h0000_6017,
			32'h0000_0117);
		dbt_host_inst.got.delete();
		$display("test delay done");
		results();
	end
endmodule : dbt_unit_test
